/* inc/card_code_map.svh */
`ifndef CARD_CODE_MAP_SVH
`define CARD_CODE_MAP_SVH

// ==================================================
// Register offsets.
`define ADDR_CTRL 4'h0
`define ADDR_CODE 4'h1
`define ADDR_UNBLK 4'h2
`define ADDR_APPID 4'h3
`define ADDR_STATUS 4'h4

// ==================================================
// Field positions.
`define CTRL_TOGGLE_EN 0
`define ST_STATE_LSB 0
`define ST_ENABLED 2
`define ST_BLOCKED 3
`define ST_UNBLK_BLOCKED 4
`define ST_ACCESS 5
`define ST_SEL_OK 6
`define ST_TRIES_LSB 8
`define ST_UTRIES_LSB 12

// ==================================================
// Reset values.
`define CTRL_RST 32'h0000_0001
`define CODE_RST 32'h0000_0000
`define UNBLK_RST 32'h0000_0000
`define APPID_RST 32'h0000_0000

// ==================================================
// Limits and encodings.
`define MAX_TRIES 2'h3
`define LEN_SHORT_MAX 8'h7f
`define LEN_LONG_LEAD 8'h81
`define LEN_LONG_MIN 8'h80
`define TAG_BAD_LO 8'h00
`define TAG_BAD_HI 8'hff

`endif

/* inc/card_code_pkg.sv */
package card_code_pkg;

    typedef enum logic [1:0] {
        ST_INACTIVE = 2'b00,
        ST_MGMT = 2'b01,
        ST_OPER = 2'b11
    } card_state_t;

    typedef enum logic [3:0] {
        OP_VERIFY = 4'h0,
        OP_DISABLE = 4'h1,
        OP_ENABLE = 4'h2,
        OP_UNBLOCK = 4'h3,
        OP_SELECT = 4'h4,
        OP_INIT = 4'h5,
        OP_READ_DIR = 4'h6,
        OP_TERMINATE = 4'h7,
        OP_POLL = 4'h8
    } cmd_op_t;

    typedef enum logic [2:0] {
        TS_TAG = 3'b000,
        TS_LEN1 = 3'b001,
        TS_LEN2 = 3'b011,
        TS_VALUE = 3'b010,
        TS_DONE = 3'b110,
        TS_ERROR = 3'b111
    } tlv_state_t;

endpackage

/* verilog/card_code_ctrl.sv */
// Function
// (RQ1) Software may forbid enable and disable; both then fail.
// (RQ2) Enable or disable on a blocked code fails with no change.
// (RQ3) Disable on an already disabled code fails without comparing.
// (RQ4) Disable with matching value on enabled code clears the indicator, succeeds.
// (RQ5) Enable on an already enabled code fails without comparing.
// (RQ6) Enable with matching value on disabled code sets the indicator, succeeds.
// (RQ7) Mismatching value on enable or disable fails, indicator unchanged.
// (RQ8) Unblock is accepted whether or not the code is blocked.
// (RQ9) Unblock fails when the unblocking key itself is blocked.
// (RQ10) Matching unblocking key clears the code's blocked state and succeeds.
// (RQ11) Mismatching unblocking key fails, blocked state unchanged.
// (RQ12) Matching select then successful initialisation enters the operation state.
// (RQ13) Failed initialisation stays in management and raises an activation failure.
// (RQ14) Directory read and session end are accepted whenever not inactive.
// (RQ15) The terminal polls presence within every 30 s of idle interface.
// (RQ16) The terminal ends the call within 5 s of an unanswered poll.
// (RQ17) The terminal ends the call within 5 s of a changed directory.
// (RQ18) Length is one byte up to 7F, or 81 then a byte above 7F.
// (RQ19) Any other length byte flags an error and rejects the whole message.
// (RQ20) Tag is one byte, never 00 or FF, and no padding is allowed.
// (RQ21) One outer object per message; inner order is the sender's concern.
// (RQ22) Card states are inactive, application management and operation.
// (RQ23) Three consecutive wrong codes block it and withdraw any granted access; access is kept when the third wrong code comes with an enable.
// (RQ24) Wrong-attempt counters clear on a correct value or successful unblock.
`timescale 1ns/10ps
`default_nettype none
`include "card_code_map.svh"

module card_code_ctrl (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic power_i,
    input wire logic cmd_valid_i,
    input wire card_code_pkg::cmd_op_t cmd_op_i,
    input wire logic [31:0] cmd_value_i,
    input wire logic [7:0] dir_i,
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_i,
    input wire logic msg_first_i,
    input wire logic msg_last_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic resp_valid_o,
    output logic resp_ok_o,
    output logic [7:0] resp_dir_o,
    output card_code_pkg::card_state_t card_state_o,
    output logic access_o,
    output logic act_fail_o,
    output logic msg_ok_o,
    output logic msg_err_o
);
    import card_code_pkg::*;

    // ==================================================
    // Register file.
    logic toggle_en_reg;
    logic [31:0] code_reg;
    logic [31:0] unblk_key_reg;
    logic [31:0] app_id_reg;
    logic enabled_reg;
    logic blocked_reg;
    logic unblk_blocked_reg;
    logic access_reg;
    logic sel_ok_reg;
    logic [1:0] tries_reg;
    logic [1:0] utries_reg;
    card_state_t state_reg;
    logic [31:0] status_word;

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            toggle_en_reg <= 1'(`CTRL_RST);
            code_reg <= `CODE_RST;
            unblk_key_reg <= `UNBLK_RST;
            app_id_reg <= `APPID_RST;
        end else if (wr_i) begin
            case (addr_i)
                `ADDR_CTRL: toggle_en_reg <= wdata_i[`CTRL_TOGGLE_EN];
                `ADDR_CODE: code_reg <= wdata_i;
                `ADDR_UNBLK: unblk_key_reg <= wdata_i;
                `ADDR_APPID: app_id_reg <= wdata_i;
                default: ;
            endcase
        end
    end

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`ST_STATE_LSB +: 2] = state_reg;
        status_word[`ST_ENABLED] = enabled_reg;
        status_word[`ST_BLOCKED] = blocked_reg;
        status_word[`ST_UNBLK_BLOCKED] = unblk_blocked_reg;
        status_word[`ST_ACCESS] = access_reg;
        status_word[`ST_SEL_OK] = sel_ok_reg;
        status_word[`ST_TRIES_LSB +: 2] = tries_reg;
        status_word[`ST_UTRIES_LSB +: 2] = utries_reg;
    end

    // Secret values read back as zero so they cannot leak over the port.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            case (addr_i)
                `ADDR_CTRL: rdata_o <= {31'h0000_0000, toggle_en_reg};
                `ADDR_APPID: rdata_o <= app_id_reg;
                `ADDR_STATUS: rdata_o <= status_word;
                default: rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

    // ==================================================
    // Command decode.
    logic live;
    logic code_match;
    logic key_match;
    logic do_cmd;

    assign live = power_i && (state_reg != ST_INACTIVE);
    assign code_match = (cmd_value_i == code_reg);
    assign key_match = (cmd_value_i == unblk_key_reg);
    assign do_cmd = cmd_valid_i && live;

    logic try_code;
    logic cmd_ok;

    // A comparison happens only when every precondition has passed.
    always_comb begin
        try_code = 1'b0;
        cmd_ok = 1'b0;
        if (do_cmd) begin
            case (cmd_op_i)
                OP_VERIFY: begin
                    if (!enabled_reg) begin
                        cmd_ok = 1'b1;
                    end else if (!blocked_reg) begin
                        try_code = 1'b1;
                        cmd_ok = code_match;
                    end
                end
                OP_DISABLE: begin
                    if (toggle_en_reg && !blocked_reg && enabled_reg) begin // [RQ1] [RQ2] [RQ3]
                        try_code = 1'b1;
                        cmd_ok = code_match; // [RQ4] [RQ7]
                    end
                end
                OP_ENABLE: begin
                    if (toggle_en_reg && !blocked_reg && !enabled_reg) begin // [RQ1] [RQ2] [RQ5]
                        try_code = 1'b1;
                        cmd_ok = code_match; // [RQ6] [RQ7]
                    end
                end
                OP_UNBLOCK: cmd_ok = !unblk_blocked_reg && key_match; // [RQ8] [RQ9] [RQ10] [RQ11]
                OP_SELECT: cmd_ok = (cmd_value_i == app_id_reg); // [RQ12]
                OP_INIT: cmd_ok = sel_ok_reg && cmd_value_i[0]; // [RQ12]
                OP_READ_DIR: cmd_ok = 1'b1; // [RQ14]
                OP_TERMINATE: cmd_ok = 1'b1; // [RQ14]
                OP_POLL: cmd_ok = 1'b1;
                default: cmd_ok = 1'b0;
            endcase
        end
    end

    // ==================================================
    // Code indicator, blocked flags and attempt counters.
    logic code_wrong;
    logic unblk_try;

    assign code_wrong = try_code && !code_match;
    assign unblk_try = do_cmd && (cmd_op_i == OP_UNBLOCK) && !unblk_blocked_reg;

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            enabled_reg <= 1'b1;
        end else if (cmd_ok && cmd_op_i == OP_DISABLE) begin
            enabled_reg <= 1'b0; // [RQ4]
        end else if (cmd_ok && cmd_op_i == OP_ENABLE) begin
            enabled_reg <= 1'b1; // [RQ6]
        end
    end

    // Counters survive session ends; only a correct value or a successful unblock clears them.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tries_reg <= 2'h0;
            blocked_reg <= 1'b0;
        end else if (unblk_try && key_match) begin
            tries_reg <= 2'h0; // [RQ24]
            blocked_reg <= 1'b0; // [RQ10]
        end else if (try_code && code_match) begin
            tries_reg <= 2'h0; // [RQ24]
        end else if (code_wrong) begin
            if (tries_reg == `MAX_TRIES - 2'h1) begin
                tries_reg <= `MAX_TRIES;
                blocked_reg <= 1'b1; // [RQ23]
            end else begin
                tries_reg <= tries_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            utries_reg <= 2'h0;
            unblk_blocked_reg <= 1'b0;
        end else if (unblk_try) begin
            if (key_match) begin
                utries_reg <= 2'h0; // [RQ24]
            end else if (utries_reg == `MAX_TRIES - 2'h1) begin
                utries_reg <= `MAX_TRIES;
                unblk_blocked_reg <= 1'b1; // [RQ9]
            end else begin
                utries_reg <= utries_reg + 2'h1;
            end
        end
    end

    // Access is granted per session and lost the moment the code blocks while enabled.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            access_reg <= 1'b0;
        end else if (!live || (do_cmd && cmd_op_i == OP_TERMINATE)) begin
            access_reg <= 1'b0;
        end else if (code_wrong && tries_reg == `MAX_TRIES - 2'h1 && enabled_reg) begin
            access_reg <= 1'b0; // [RQ23]
        end else if (cmd_ok && (cmd_op_i == OP_VERIFY || cmd_op_i == OP_DISABLE
                                || cmd_op_i == OP_ENABLE || cmd_op_i == OP_UNBLOCK)) begin
            access_reg <= 1'b1;
        end
    end

    // ==================================================
    // Card state.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= ST_INACTIVE;
        end else if (!power_i) begin
            state_reg <= ST_INACTIVE; // [RQ22]
        end else begin
            case (state_reg)
                ST_INACTIVE: state_reg <= ST_MGMT; // [RQ22]
                ST_MGMT: begin
                    if (cmd_ok && cmd_op_i == OP_INIT) begin
                        state_reg <= ST_OPER; // [RQ12]
                    end
                end
                ST_OPER: begin
                    if (do_cmd && cmd_op_i == OP_TERMINATE) begin
                        state_reg <= ST_MGMT; // [RQ14]
                    end
                end
                default: state_reg <= ST_INACTIVE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sel_ok_reg <= 1'b0;
        end else if (!live || (do_cmd && cmd_op_i == OP_TERMINATE)) begin
            sel_ok_reg <= 1'b0;
        end else if (do_cmd && cmd_op_i == OP_SELECT) begin
            sel_ok_reg <= cmd_ok; // [RQ12]
        end else if (do_cmd && cmd_op_i == OP_INIT) begin
            sel_ok_reg <= 1'b0;
        end
    end

    // ==================================================
    // Command answer.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            resp_valid_o <= 1'b0;
            resp_ok_o <= 1'b0;
            resp_dir_o <= 8'h00;
            act_fail_o <= 1'b0;
        end else begin
            resp_valid_o <= cmd_valid_i;
            resp_ok_o <= cmd_ok;
            resp_dir_o <= (do_cmd && cmd_op_i == OP_POLL) ? dir_i : 8'h00;
            act_fail_o <= do_cmd && cmd_op_i == OP_INIT && !cmd_ok; // [RQ13]
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            card_state_o <= ST_INACTIVE;
            access_o <= 1'b0;
        end else begin
            card_state_o <= state_reg;
            access_o <= access_reg;
        end
    end

    // ==================================================
    // Data object check on incoming payloads.
    tlv_state_t tlv_reg;
    logic [7:0] remain_reg;
    tlv_state_t tlv_next;
    logic [7:0] remain_next;

    always_comb begin
        tlv_next = tlv_reg;
        remain_next = remain_reg;
        if (byte_valid_i) begin
            case (msg_first_i ? TS_TAG : tlv_reg)
                TS_TAG: begin
                    if (byte_i == `TAG_BAD_LO || byte_i == `TAG_BAD_HI) begin
                        tlv_next = TS_ERROR; // [RQ20]
                    end else begin
                        tlv_next = TS_LEN1;
                    end
                end
                TS_LEN1: begin
                    if (byte_i <= `LEN_SHORT_MAX) begin
                        remain_next = byte_i; // [RQ18]
                        tlv_next = (byte_i == 8'h00) ? TS_DONE : TS_VALUE;
                    end else if (byte_i == `LEN_LONG_LEAD) begin
                        tlv_next = TS_LEN2; // [RQ18]
                    end else begin
                        tlv_next = TS_ERROR; // [RQ19]
                    end
                end
                TS_LEN2: begin
                    if (byte_i >= `LEN_LONG_MIN) begin
                        remain_next = byte_i; // [RQ18]
                        tlv_next = TS_VALUE;
                    end else begin
                        tlv_next = TS_ERROR; // [RQ19]
                    end
                end
                TS_VALUE: begin
                    remain_next = remain_reg - 8'h01;
                    tlv_next = (remain_reg == 8'h01) ? TS_DONE : TS_VALUE;
                end
                TS_DONE: tlv_next = TS_ERROR; // [RQ20] [RQ21]
                default: tlv_next = TS_ERROR;
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tlv_reg <= TS_TAG;
            remain_reg <= 8'h00;
        end else if (byte_valid_i && msg_last_i) begin
            tlv_reg <= TS_TAG;
            remain_reg <= 8'h00;
        end else begin
            tlv_reg <= tlv_next;
            remain_reg <= remain_next;
        end
    end

    // The verdict covers the whole message, so one bad byte rejects it all.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            msg_ok_o <= 1'b0;
            msg_err_o <= 1'b0;
        end else begin
            msg_ok_o <= byte_valid_i && msg_last_i && tlv_next == TS_DONE;
            msg_err_o <= byte_valid_i && msg_last_i && tlv_next != TS_DONE; // [RQ19]
        end
    end

endmodule
`default_nettype wire

/* bench/card_code_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module card_code_sva (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic power_i,
    input wire logic cmd_valid_i,
    input wire card_code_pkg::cmd_op_t cmd_op_i,
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_i,
    input wire logic msg_first_i,
    input wire logic msg_last_i,
    input wire logic resp_valid_o,
    input wire logic resp_ok_o,
    input wire card_code_pkg::card_state_t card_state_o,
    input wire logic act_fail_o,
    input wire logic msg_ok_o,
    input wire logic msg_err_o
);
    import card_code_pkg::*;
    logic tag_bad_reg;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);
    // ==========================================
    // Remembers whether the current message opened with a forbidden tag.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tag_bad_reg <= 1'b0;
        end else if (byte_valid_i && msg_first_i) begin
            tag_bad_reg <= (byte_i == 8'h00) || (byte_i == 8'hff);
        end
    end
    // ==========================================
    // Checks.
    resp_follows_a: assert property (cmd_valid_i |=> resp_valid_o)
        else $error("no response after command");
    unpowered_refuse_a: assert property (cmd_valid_i && !power_i |=> !resp_ok_o)
        else $error("command accepted while unpowered");
    power_inactive_a: assert property (!power_i |-> ##[1:2] card_state_o == ST_INACTIVE)
        else $error("state not inactive after power loss");
    dir_read_ok_a: assert property (cmd_valid_i && cmd_op_i == OP_READ_DIR && power_i && $past(power_i)
        && card_state_o != ST_INACTIVE |=> resp_ok_o)
        else $error("directory read refused");
    end_session_ok_a: assert property (cmd_valid_i && cmd_op_i == OP_TERMINATE && power_i && $past(power_i)
        && card_state_o != ST_INACTIVE |=> resp_ok_o ##1 card_state_o == ST_MGMT)
        else $error("session end refused");
    activate_oper_a: assert property (resp_valid_o && resp_ok_o && $past(cmd_op_i) == OP_INIT
        |=> card_state_o == ST_OPER)
        else $error("no operation state after init");
    init_fail_a: assert property (resp_valid_o && !resp_ok_o && $past(cmd_op_i) == OP_INIT && $past(power_i)
        |-> act_fail_o)
        else $error("failed init not flagged");
    fail_cause_a: assert property (act_fail_o |-> resp_valid_o && !resp_ok_o && $past(cmd_op_i) == OP_INIT)
        else $error("activation failure without failed init");
    msg_verdict_a: assert property ((msg_ok_o || msg_err_o) |-> $past(byte_valid_i) && $past(msg_last_i)
        && !(msg_ok_o && msg_err_o))
        else $error("message verdict without last byte");
    bad_tag_a: assert property (byte_valid_i && msg_last_i && !msg_first_i && tag_bad_reg
        |=> msg_err_o && !msg_ok_o)
        else $error("forbidden tag accepted");
    cover property (resp_valid_o && resp_ok_o && $past(cmd_op_i) == OP_INIT);
    cover property (act_fail_o);
    cover property (msg_err_o);
endmodule
bind card_code_ctrl card_code_sva chk (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .power_i(power_i), .cmd_valid_i(cmd_valid_i),
    .cmd_op_i(cmd_op_i), .byte_valid_i(byte_valid_i), .byte_i(byte_i), .msg_first_i(msg_first_i),
    .msg_last_i(msg_last_i), .resp_valid_o(resp_valid_o), .resp_ok_o(resp_ok_o),
    .card_state_o(card_state_o), .act_fail_o(act_fail_o), .msg_ok_o(msg_ok_o), .msg_err_o(msg_err_o)
);
`default_nettype wire

/* bench/terminal_model.sv */
`timescale 1ns/10ps
`default_nettype none
module terminal_model (
    input wire logic mclk_i,
    input wire logic resp_valid_i,
    input wire logic resp_ok_i,
    output var logic cmd_valid_o,
    output var card_code_pkg::cmd_op_t cmd_op_o,
    output var logic [31:0] cmd_value_o
);
    import card_code_pkg::*;
    initial begin
        cmd_valid_o = 1'b0;
        cmd_op_o = OP_POLL;
        cmd_value_o = 32'h0000_0000;
    end
    // Sends one whole command, then takes the answer in its single reply cycle.
    // The status pre-check is skipped on purpose so that the card's own refusals are seen.
    task automatic issue(input cmd_op_t op, input logic [31:0] val, output logic ok);
        @(posedge mclk_i);
        cmd_valid_o <= 1'b1;
        cmd_op_o <= op;
        cmd_value_o <= val;
        @(posedge mclk_i);
        cmd_valid_o <= 1'b0;
        cmd_value_o <= ~val;
        @(negedge mclk_i);
        ok = resp_valid_i ? resp_ok_i : 1'bx;
    endtask
endmodule
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "card_code_map.svh"
module tb_top;
    import card_code_pkg::*;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic power_i = 1'b1;
    logic cmd_valid_i, byte_valid_i, msg_first_i, msg_last_i, wr_i, rd_i, ok;
    logic resp_valid_o, resp_ok_o, access_o, act_fail_o, msg_ok_o, msg_err_o;
    cmd_op_t cmd_op_i;
    card_state_t card_state_o;
    logic [31:0] cmd_value_i, wdata_i, rdata_o, d;
    logic [7:0] dir_i, byte_i, resp_dir_o;
    logic [3:0] addr_i;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #5 mclk_i = ~mclk_i;
    terminal_model term (.mclk_i(mclk_i), .resp_valid_i(resp_valid_o), .resp_ok_i(resp_ok_o),
        .cmd_valid_o(cmd_valid_i), .cmd_op_o(cmd_op_i), .cmd_value_o(cmd_value_i));
    card_code_ctrl dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .power_i(power_i), .cmd_valid_i(cmd_valid_i),
        .cmd_op_i(cmd_op_i), .cmd_value_i(cmd_value_i), .dir_i(dir_i), .byte_valid_i(byte_valid_i),
        .byte_i(byte_i), .msg_first_i(msg_first_i), .msg_last_i(msg_last_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .resp_valid_o(resp_valid_o),
        .resp_ok_o(resp_ok_o), .resp_dir_o(resp_dir_o), .card_state_o(card_state_o), .access_o(access_o),
        .act_fail_o(act_fail_o), .msg_ok_o(msg_ok_o), .msg_err_o(msg_err_o));
    // ==========================================
    // Shared tasks.
    task automatic end_of_test();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        wdata_i <= ~v;
    endtask
    task automatic reg_rd(input logic [3:0] a);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(negedge mclk_i);
        d = rdata_o;
    endtask
    task automatic st(input logic [31:0] m, input logic [31:0] e, input string n);
        reg_rd(`ADDR_STATUS);
        check(n, d & m, e);
    endtask
    task automatic cmd(input cmd_op_t op, input logic [31:0] v, input logic e, input string n);
        term.issue(op, v, ok);
        check(n, {31'h0, ok}, {31'h0, e});
    endtask
    task automatic send_msg(input logic [7:0] tag, input logic [7:0] l1, input logic [7:0] l2,
        input int two, input int nval, input logic e, input string n);
        logic [7:0] q[$];
        q = {tag, l1};
        if (two != 0) begin
            q.push_back(l2);
        end
        repeat (nval) q.push_back(8'h55);
        foreach (q[i]) begin
            @(posedge mclk_i);
            byte_valid_i <= 1'b1;
            byte_i <= q[i];
            msg_first_i <= (i == 0);
            msg_last_i <= (i == q.size() - 1);
        end
        @(posedge mclk_i);
        byte_valid_i <= 1'b0;
        msg_last_i <= 1'b0;
        @(negedge mclk_i);
        check(n, {30'h0, msg_ok_o, msg_err_o}, {30'h0, e, !e});
    endtask
    // ==========================================
    // Scenarios.
    task automatic t_code();
        reg_rd(`ADDR_CTRL);
        check("ctrl", d, `CTRL_RST);
        st(32'h0000_337f, 32'h0000_0005, "status_rst");
        reg_wr(`ADDR_CODE, 32'h0000_1234);
        reg_rd(`ADDR_CODE);
        check("code_wo", d, 32'h0);
        reg_rd(4'hf);
        check("unmapped", d, 32'h0);
        cmd(OP_DISABLE, 32'h1111, 1'b0, "dis_bad");
        st(32'h30c, 32'h104, "dis_bad_st");
        cmd(OP_DISABLE, 32'h1234, 1'b1, "dis_ok");
        st(32'h30c, 32'h000, "dis_ok_st");
        cmd(OP_DISABLE, 32'h1234, 1'b0, "dis_twice");
        st(32'h30c, 32'h000, "dis_twice_st");
        cmd(OP_ENABLE, 32'h9999, 1'b0, "en_bad");
        st(32'h30c, 32'h100, "en_bad_st");
        cmd(OP_ENABLE, 32'h1234, 1'b1, "en_ok");
        cmd(OP_ENABLE, 32'h1234, 1'b0, "en_twice");
        st(32'h30c, 32'h004, "en_st");
        reg_wr(`ADDR_CTRL, 32'h0);
        cmd(OP_DISABLE, 32'h1234, 1'b0, "dis_forbid");
        st(32'h30c, 32'h004, "forbid_st");
        reg_wr(`ADDR_CTRL, 32'h1);
    endtask
    task automatic t_block();
        check("access_on", {31'h0, access_o}, 32'h1);
        repeat (3) cmd(OP_VERIFY, 32'h0, 1'b0, "ver_bad");
        st(32'h2c, 32'h0c, "blocked_st");
        check("access_off", {31'h0, access_o}, 32'h0);
        cmd(OP_DISABLE, 32'h1234, 1'b0, "dis_blocked");
        reg_wr(`ADDR_UNBLK, 32'h0000_beef);
        cmd(OP_UNBLOCK, 32'h0bad, 1'b0, "unb_bad");
        st(32'h330c, 32'h130c, "unb_bad_st");
        cmd(OP_UNBLOCK, 32'hbeef, 1'b1, "unb_ok");
        st(32'h330c, 32'h0004, "unb_ok_st");
        cmd(OP_UNBLOCK, 32'hbeef, 1'b1, "unb_free");
        repeat (3) cmd(OP_UNBLOCK, 32'h0, 1'b0, "unb_bad3");
        st(32'h10, 32'h10, "key_blocked");
        cmd(OP_UNBLOCK, 32'hbeef, 1'b0, "unb_keyblk");
    endtask
    task automatic t_session();
        reg_wr(`ADDR_APPID, 32'h0000_0042);
        reg_rd(`ADDR_APPID);
        check("appid", d, 32'h42);
        cmd(OP_SELECT, 32'h41, 1'b0, "sel_bad");
        cmd(OP_SELECT, 32'h42, 1'b1, "sel_ok");
        cmd(OP_INIT, 32'h0, 1'b0, "init_bad");
        check("act_fail", {31'h0, act_fail_o}, 32'h1);
        repeat (2) @(negedge mclk_i);
        check("mgmt", 32'(card_state_o), 32'(ST_MGMT));
        cmd(OP_SELECT, 32'h42, 1'b1, "sel_again");
        cmd(OP_INIT, 32'h1, 1'b1, "init_ok");
        repeat (2) @(negedge mclk_i);
        check("oper", 32'(card_state_o), 32'(ST_OPER));
        cmd(OP_READ_DIR, 32'h0, 1'b1, "dir_rd");
        cmd(OP_POLL, 32'h0, 1'b1, "poll");
        check("poll_dir", 32'(resp_dir_o), 32'h5a);
        cmd(OP_TERMINATE, 32'h0, 1'b1, "term");
        repeat (2) @(negedge mclk_i);
        check("term_st", 32'(card_state_o), 32'(ST_MGMT));
        @(posedge mclk_i);
        power_i <= 1'b0;
        repeat (3) @(negedge mclk_i);
        check("inactive", 32'(card_state_o), 32'(ST_INACTIVE));
        cmd(OP_READ_DIR, 32'h0, 1'b0, "dir_off");
        @(posedge mclk_i);
        power_i <= 1'b1;
        repeat (3) @(negedge mclk_i);
        check("repower", 32'(card_state_o), 32'(ST_MGMT));
    endtask
    task automatic t_msg();
        send_msg(8'ha0, 8'h01, 8'h00, 0, 1, 1'b1, "m_short");
        send_msg(8'ha0, 8'h00, 8'h00, 0, 0, 1'b1, "m_empty");
        send_msg(8'ha0, 8'h7f, 8'h00, 0, 127, 1'b1, "m_7f");
        send_msg(8'ha0, 8'h81, 8'h80, 1, 128, 1'b1, "m_long");
        send_msg(8'h00, 8'h01, 8'h00, 0, 1, 1'b0, "m_tag00");
        send_msg(8'hff, 8'h01, 8'h00, 0, 1, 1'b0, "m_tagff");
        send_msg(8'ha0, 8'h80, 8'h00, 0, 0, 1'b0, "m_len80");
        send_msg(8'ha0, 8'h82, 8'h00, 0, 1, 1'b0, "m_len82");
        send_msg(8'ha0, 8'h81, 8'h7f, 1, 127, 1'b0, "m_len2lo");
        send_msg(8'ha0, 8'h02, 8'h00, 0, 1, 1'b0, "m_early");
        send_msg(8'ha0, 8'h01, 8'h00, 0, 2, 1'b0, "m_extra");
    endtask
    // ==========================================
    // Main sequence and time limit.
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    initial begin
        dir_i = 8'h5a;
        byte_valid_i = 1'b0;
        byte_i = 8'h00;
        msg_first_i = 1'b0;
        msg_last_i = 1'b0;
        addr_i = 4'h0;
        wdata_i = 32'h0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        t_code();
        t_block();
        t_session();
        t_msg();
        end_of_test();
    end
endmodule
`default_nettype wire
